// >>> design/fchsc_top.sv
// four channel pulse counter with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "fchsc_map.svh"
module fchsc_top
  import fchsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // count and reset contacts
  input wire logic inputA,
  input wire logic inputB,
  input wire logic resetInLowPair,
  input wire logic inputC,
  input wire logic inputD,
  input wire logic resetInHighPair,
  // switched outputs and channel flags
  output logic [7:0] compareOut,
  output logic [3:0] activeFlag
);
  localparam int NCH = 4;

  logic [31:0] ctrl_ff;
  logic [31:0] ocfg_ff;
  logic [7:0] out_ff;
  logic [7:0] nxt_out;
  logic [31:0] tgt_ff [NCH];
  logic [31:0] hrdata_ff;
  logic [7:0] wrAddr_ff;
  fchsc_phase_type phase_ff;
  logic [5:0] pin_ff;
  logic [31:0] cnt [NCH];
  logic [NCH-1:0] hit;
  logic [NCH-1:0] step;
  logic [NCH-1:0] down;
  logic [NCH-1:0] clr;
  logic [NCH-1:0] ld;

  // two-phase decode: {step, down}; quadrature uses both edges of a
  function automatic logic [1:0] pairDecode(input logic pdir,
      input logic aRise, input logic aFall, input logic b);
    logic [1:0] r;
    r = 2'b00;
    if (aRise) begin
      r = {1'b1, b};
    end else if (aFall && !pdir) begin
      r = {1'b1, ~b};
    end
    return r;
  endfunction

  // edge detection of the contacts
  wire logic [5:0] pins = {resetInHighPair, inputD, inputC,
                           resetInLowPair, inputB, inputA};
  wire logic [5:0] rise = pins & ~pin_ff;
  wire logic [5:0] fall = ~pins & pin_ff;

  // mode and per channel controls
  wire logic twoPh = ctrl_ff[`FCHSC_B_TWOPH];
  wire logic [3:0] dirDown = ctrl_ff[`FCHSC_F_DOWN +: 4];
  wire logic [3:0] chEn = ctrl_ff[`FCHSC_F_EN +: 4];
  wire logic [3:0] active = chEn & (twoPh ? 4'h5 : 4'hF);
  wire logic [1:0] dec0 = pairDecode(ctrl_ff[`FCHSC_B_PDIR_LO],
                                     rise[0], fall[0], pins[1]);
  wire logic [1:0] dec2 = pairDecode(ctrl_ff[`FCHSC_B_PDIR_HI],
                                     rise[3], fall[3], pins[4]);

  // step and direction per channel
  assign step[0] = active[0] & (twoPh ? dec0[1] : rise[0]);
  assign down[0] = twoPh ? dec0[0] : dirDown[0];
  assign step[1] = active[1] & rise[1];
  assign down[1] = dirDown[1];
  assign step[2] = active[2] & (twoPh ? dec2[1] : rise[3]);
  assign down[2] = twoPh ? dec2[0] : dirDown[2];
  assign step[3] = active[3] & rise[4];
  assign down[3] = dirDown[3];

  // reset inputs routed to the selected channel of each pair
  wire logic rsLo = ctrl_ff[`FCHSC_B_RSEL_LO];
  wire logic rsHi = ctrl_ff[`FCHSC_B_RSEL_HI];
  assign clr[0] = rise[2] & ~rsLo;
  assign clr[1] = rise[2] & rsLo;
  assign clr[2] = rise[5] & ~rsHi;
  assign clr[3] = rise[5] & rsHi;

  // bus decode
  wire logic addrPh = hsel & hready & htrans[1];
  wire logic wrPh = (phase_ff == PH_WR);
  wire logic [1:0] rdIdx = haddr[3:2];
  wire logic [1:0] wrIdx = wrAddr_ff[3:2];
  wire logic wrElap = wrPh && (wrAddr_ff[7:4] == `FCHSC_ELAP_BASE);
  wire logic wrTgt = wrPh && (wrAddr_ff[7:4] == `FCHSC_TGT_BASE);
  wire logic [31:0] statVal = {20'h00000, out_ff, active};
  wire logic [31:0] rdVal =
      (haddr == `FCHSC_CTRL_OFS) ? ctrl_ff :
      (haddr == `FCHSC_STAT_OFS) ? statVal :
      (haddr == `FCHSC_OCFG_OFS) ? ocfg_ff :
      (haddr == `FCHSC_OUT_OFS) ? {24'h000000, out_ff} :
      (haddr[7:4] == `FCHSC_ELAP_BASE) ? cnt[rdIdx] :
      (haddr[7:4] == `FCHSC_TGT_BASE) ? tgt_ff[rdIdx] : 32'h0000_0000;

  // four channels
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    assign ld[n] = wrElap && (wrIdx == 2'(n));
    fchsc_channel #(.WIDTH(32)) u_ch (
      .core_clk(core_clk),
      .rstn(rstn),
      .step(step[n]),
      .down(down[n]),
      .clear(clr[n]),
      .load(ld[n]),
      .loadVal(hwdata),
      .target(tgt_ff[n]),
      .count(cnt[n]),
      .hit(hit[n])
    );
  end

  // target hits drive the chosen output; hits override a bus write
  always_comb begin
    nxt_out = out_ff;
    if (wrPh && wrAddr_ff == `FCHSC_OUT_OFS) begin
      nxt_out = hwdata[7:0];
    end
    for (int n = 0; n < NCH; n++) begin
      if (hit[n] && ocfg_ff[8*n + `FCHSC_OC_EN]) begin
        nxt_out[ocfg_ff[8*n + `FCHSC_OC_SEL +: 3]] =
            ocfg_ff[8*n + `FCHSC_OC_LEVEL];
      end
    end
  end

  // contact history and bus phase
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_ff <= 6'h00;
      phase_ff <= PH_IDLE;
      wrAddr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      pin_ff <= pins;
      phase_ff <= (addrPh && hwrite) ? PH_WR : PH_IDLE;
      if (addrPh) begin
        wrAddr_ff <= haddr;
      end
      if (addrPh && !hwrite) begin
        hrdata_ff <= rdVal;
      end
    end
  end

  // software registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_ff <= `FCHSC_CTRL_RST;
      ocfg_ff <= `FCHSC_OCFG_RST;
      out_ff <= `FCHSC_OUT_RST;
    end else begin
      out_ff <= nxt_out;
      if (wrPh && wrAddr_ff == `FCHSC_CTRL_OFS) begin
        ctrl_ff <= hwdata;
      end
      if (wrPh && wrAddr_ff == `FCHSC_OCFG_OFS) begin
        ocfg_ff <= hwdata;
      end
    end
  end

  // target registers, untouched by the reset inputs
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int n = 0; n < NCH; n++) begin
        tgt_ff[n] <= 32'h0000_0000;
      end
    end else if (wrTgt) begin
      tgt_ff[wrIdx] <= hwdata;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign compareOut = out_ff;
  assign activeFlag = active;

  // checks
  sequence seqUpAtMax(int n);
    step[n] && !down[n] && !clr[n] && !ld[n] && cnt[n] == 32'h7FFF_FFFF;
  endsequence
  sequence seqDownAtMin(int n);
    step[n] && down[n] && !clr[n] && !ld[n] && cnt[n] == 32'h8000_0000;
  endsequence

  chk_wrap_up: assert property (@(posedge core_clk)
    disable iff (!rstn) seqUpAtMax(0) |=> cnt[0] == 32'h8000_0000)
    else $error("count did not wrap to minimum");

  chk_wrap_down: assert property (@(posedge core_clk)
    disable iff (!rstn) seqDownAtMin(1) |=> cnt[1] == 32'h7FFF_FFFF)
    else $error("count did not wrap to maximum");

  chk_reset_clear: assert property (@(posedge core_clk)
    disable iff (!rstn) $rose(resetInLowPair) && !rsLo
      |=> cnt[0] == 32'h0000_0000 && $stable(tgt_ff[0]))
    else $error("reset input did not clear channel zero");

  chk_reset_route: assert property (@(posedge core_clk)
    disable iff (!rstn) $rose(resetInHighPair) && rsHi && !ld[3]
      |=> cnt[3] == 32'h0
      && ($stable(cnt[2]) || $past(step[2] || ld[2])))
    else $error("high pair reset went to wrong channel");

  chk_match_output: assert property (@(posedge core_clk)
    disable iff (!rstn) hit[2] && ocfg_ff[20] && !hit[3]
      |=> out_ff[$past(ocfg_ff[18:16])] == $past(ocfg_ff[19]))
    else $error("target match did not switch output");

  chk_twophase_idle: assert property (@(posedge core_clk)
    disable iff (!rstn) twoPh && !clr[1] && !ld[1] ##1 twoPh
      |-> $stable(cnt[1]))
    else $error("channel one counted in two-phase mode");

  chk_single_count: assert property (@(posedge core_clk)
    disable iff (!rstn) !twoPh && active[3] && $rose(inputD)
      && !clr[3] && !ld[3] |=> cnt[3] == $past(cnt[3])
      + ($past(dirDown[3]) ? 32'hFFFF_FFFF : 32'h1))
    else $error("channel three missed a pulse");

  chk_disabled_hold: assert property (@(posedge core_clk)
    disable iff (!rstn) !chEn[3] && !clr[3] && !ld[3] |=> $stable(cnt[3]))
    else $error("disabled channel counted");

  chk_step_size: assert property (@(posedge core_clk)
    disable iff (!rstn) !clr[0] && !ld[0] |=> (cnt[0] - $past(cnt[0]))
      inside {32'h0, 32'h1, 32'hFFFF_FFFF})
    else $error("count moved by more than one");

  chk_read_data: assert property (@(posedge core_clk)
    disable iff (!rstn) addrPh && !hwrite && haddr == `FCHSC_STAT_OFS
      |=> hrdata[3:0] == $past(active))
    else $error("status read returned wrong flags");
endmodule
`default_nettype wire

// >>> design/fchsc_map.svh
// register offsets, field positions and reset values of the pulse counter
`ifndef FCHSC_MAP_SVH
`define FCHSC_MAP_SVH

`define FCHSC_CTRL_OFS 8'h00
`define FCHSC_STAT_OFS 8'h04
`define FCHSC_OCFG_OFS 8'h08
`define FCHSC_OUT_OFS 8'h0C
`define FCHSC_ELAP_BASE 4'h1
`define FCHSC_TGT_BASE 4'h2

`define FCHSC_B_TWOPH 0
`define FCHSC_B_PDIR_LO 1
`define FCHSC_B_PDIR_HI 2
`define FCHSC_F_DOWN 4
`define FCHSC_B_RSEL_LO 8
`define FCHSC_B_RSEL_HI 9
`define FCHSC_F_EN 16

`define FCHSC_OC_SEL 0
`define FCHSC_OC_LEVEL 3
`define FCHSC_OC_EN 4

`define FCHSC_CTRL_RST 32'h0000_0000
`define FCHSC_OCFG_RST 32'h0000_0000
`define FCHSC_OUT_RST 8'h00

`endif

// >>> design/fchsc_pkg.sv
// types shared by the pulse counter files
package fchsc_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_WR = 2'b10
  } fchsc_phase_type;

  typedef logic signed [31:0] fchsc_count_type;

endpackage

// >>> design/fchsc_channel.sv
// one counter channel: wrapping up/down counter with clear, load and target compare
`timescale 1ns/10ps
`default_nettype none
module fchsc_channel #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // count control
  input wire logic step,
  input wire logic down,
  input wire logic clear,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadVal,
  input wire logic [WIDTH-1:0] target,
  // state
  output logic [WIDTH-1:0] count,
  output logic hit
);
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  wire logic [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};

  // clear wins over load, load over a step; the sum wraps by width
  always_comb begin
    if (clear) begin
      nxt_cnt = '0;
    end else if (load) begin
      nxt_cnt = loadVal;
    end else if (step) begin
      nxt_cnt = down ? cnt_ff - one : cnt_ff + one;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // counted value reaching the target
  assign hit = step && !clear && !load && (nxt_cnt == target);
  assign count = cnt_ff;

  // count register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

// >>> tb/fchsc_sensor.sv
// sensor model driving the count and reset contacts
`timescale 1ns/10ps
`default_nettype none
module fchsc_sensor (
  // clock
  input wire logic core_clk,
  // pulse request and held level, one bit per contact
  input wire logic [5:0] req,
  input wire logic [5:0] lvl,
  // contacts: a, b, low reset, c, d, high reset
  output logic [5:0] pin
);
  logic [5:0] hi_ff = 6'h00;
  // a request shows on the contact one edge later, over a held level
  always @(posedge core_clk) begin
    hi_ff <= req;
  end
  assign pin = lvl ^ hi_ff;
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the four channel pulse counter
`timescale 1ns/10ps
`default_nettype none
`include "fchsc_map.svh"
`define CK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %h got %h", nm, e, g); fails++; end end
module testbench;
  localparam int PER = 1000;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, lf;
  logic hreadyout, hresp;
  logic [7:0] compareOut;
  logic [3:0] activeFlag;
  logic [5:0] req = 6'h00;
  logic [5:0] lvl = 6'h00;
  wire logic [5:0] pin;
  int fails = 0;
  int n_compared = 0;
  int mc[4];
  int tg;
  fchsc_top uut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .inputA(pin[0]),
    .inputB(pin[1]), .resetInLowPair(pin[2]), .inputC(pin[3]),
    .inputD(pin[4]), .resetInHighPair(pin[5]),
    .compareOut(compareOut), .activeFlag(activeFlag));
  fchsc_sensor snsr (.core_clk(core_clk), .req(req), .lvl(lvl), .pin(pin));
  // clock at 20 MHz
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // random source, seeded with 29
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ea(input int ch);
    return {`FCHSC_ELAP_BASE, 2'(ch), 2'b00};
  endfunction
  function automatic logic [7:0] ta(input int ch);
    return {`FCHSC_TGT_BASE, 2'(ch), 2'b00};
  endfunction
  task automatic conclude;
    $display("compared %0d, fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one edge, then more until hready is seen high, bounded
  task automatic edge_rdy;
    int i;
    i = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 100) begin
        fails++;
        conclude();
      end
      @(posedge core_clk);
    end
  endtask
  // single ahb-lite transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    edge_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask
  // write, then one idle edge so a following read sees the new value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge core_clk);
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CK($sformatf("reg %h", a), e, rd)
    `CK("bus answer", 2'b10, {hreadyout, hresp})
  endtask
  // pulse two cycles high, one pulse per period of 20 kHz
  task automatic pulse(input int l);
    req[l] <= 1'b1;
    repeat (2) @(posedge core_clk);
    req[l] <= 1'b0;
    repeat (PER - 2) @(posedge core_clk);
  endtask
  // pulse a channel's contact and step the reference count
  task automatic stepc(input int ch, input int n, input int dn);
    repeat (n) begin
      pulse(ch + (ch > 1));
      mc[ch] = dn ? mc[ch] - 1 : mc[ch] + 1;
    end
  endtask
  // one quadrature cycle on c and d; each edge of c counts one
  task automatic quad(input int dn);
    int p;
    for (int k = 0; k < 4; k++) begin
      p = ((k & 1) == dn) ? 3 : 4;
      lvl[p] <= ~lvl[p];
      if (p == 3) mc[2] = dn ? mc[2] - 1 : mc[2] + 1;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // main sequence
  initial begin
    lf = 32'h1D;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    ck(`FCHSC_CTRL_OFS, 32'h0);
    ck(8'hF0, 32'h0);
    `CK("compareOut", 8'h00, compareOut)
    // single phase, all enabled, channels one and three count down
    wr(`FCHSC_CTRL_OFS, 32'h000F_00A0);
    `CK("activeFlag", 4'hF, activeFlag)
    for (int ch = 0; ch < 4; ch++) begin
      lf = nx(lf);
      mc[ch] = lf;
      wr(ea(ch), lf);
    end
    for (int ch = 0; ch < 4; ch++) stepc(ch, 3, ch & 1);
    for (int ch = 0; ch < 4; ch++) ck(ea(ch), mc[ch]);
    // wrap at both ends of the signed range
    mc[0] = 32'h7FFF_FFFF;
    mc[1] = 32'h8000_0000;
    wr(ea(0), mc[0]);
    wr(ea(1), mc[1]);
    stepc(0, 1, 0);
    stepc(1, 1, 1);
    ck(ea(0), 32'h8000_0000);
    ck(ea(1), 32'h7FFF_FFFF);
    // target match drives output six high, then low
    for (int k = 0; k < 2; k++) begin
      lf = nx(lf);
      mc[2] = int'($signed(lf[22:0]));
      tg = mc[2] + 3;
      wr(ea(2), mc[2]);
      wr(ta(2), tg);
      wr(`FCHSC_OCFG_OFS, k ? 32'h0016_0000 : 32'h001E_0000);
      stepc(2, 3, 0);
      `CK("compareOut", k ? 8'h00 : 8'h40, compareOut)
    end
    // software drives the outputs; status shows them with the flags
    wr(`FCHSC_OUT_OFS, 32'h0000_0081);
    `CK("compareOut", 8'h81, compareOut)
    ck(`FCHSC_STAT_OFS, 32'h0000_081F);
    // reset contacts clear the assigned channel only
    pulse(5);
    mc[2] = 0;
    ck(ea(2), mc[2]);
    ck(ta(2), tg);
    pulse(2);
    mc[0] = 0;
    ck(ea(0), 32'h0);
    ck(ea(1), mc[1]);
    wr(`FCHSC_CTRL_OFS, 32'h000F_01A0);
    pulse(2);
    ck(ea(1), 32'h0);
    // a disabled channel ignores its pulses
    wr(`FCHSC_CTRL_OFS, 32'h0007_01A0);
    `CK("activeFlag", 4'h7, activeFlag)
    pulse(4);
    ck(ea(3), mc[3]);
    // high pair reset moved to channel three, even while disabled
    wr(`FCHSC_CTRL_OFS, 32'h0007_03A0);
    pulse(5);
    mc[3] = 0;
    ck(ea(3), mc[3]);
    ck(ea(2), mc[2]);
    // two-phase pulse and direction on the low pair
    wr(`FCHSC_CTRL_OFS, 32'h000F_0003);
    `CK("activeFlag", 4'h5, activeFlag)
    lvl[1] <= 1'b1;
    @(posedge core_clk);
    stepc(0, 2, 1);
    lvl[1] <= 1'b0;
    @(posedge core_clk);
    stepc(0, 1, 0);
    ck(ea(0), mc[0]);
    ck(ea(1), 32'h0);
    // two-phase quadrature on the high pair: forward twice, back once
    quad(0);
    quad(0);
    quad(1);
    ck(ea(2), mc[2]);
    ck(ea(3), mc[3]);
    conclude();
  end
endmodule
`default_nettype wire
